// File: pmpsc_cfg.svh
`ifndef PMPSC_CFG_SVH
`define PMPSC_CFG_SVH
// ----------------------------------------
// Resource bank layout
// ----------------------------------------
`define RES_NUM 8
`define RES_AW 3
`define RES_DW 8
`define RES_EN_BIT 0
`define RES_SLP_HI 2
`define RES_SLP_LO 1
`define RES_DEFAULTS 64'h0000000000000000
`define SUB_NUM 4
`define SUB_LINKS 32'h80402003
// ----------------------------------------
// Sequence memory layout
// ----------------------------------------
`define OTP_AW 5
`define OTP_DW 13
`define STEP_LAST 12
`define STEP_IO 11
`define STEP_ADDR_HI 10
`define STEP_ADDR_LO 8
`define STEP_DATA_HI 7
`define OTP_LAST_ADDR 5'h13
`define SEQ_LAST_STEP 2'h3
// ----------------------------------------
// Sequencing time base
// ----------------------------------------
`define CORE_CLK_HZ 25000000
`define RC_FREQ_HZ 32768
`define RC_TICK_CYC (`CORE_CLK_HZ / `RC_FREQ_HZ)
`define TICK_W 10
`define SYNC_W 9
`endif

// File: pmpsc_pkg.sv
`default_nettype none
package pmpsc_pkg;
  // Power state of the device
  typedef enum logic [2:0] {
    PWR_NOSUP = 3'h0, // System rail below power-on reset
    PWR_LOWSUP = 3'h1, // Rail between reset and low threshold
    PWR_OFF = 3'h2, // Waiting for start-up
    PWR_ACT = 3'h3, // Fully powered
    PWR_SLP = 3'h4 // Low-power mode
  } pmpsc_pwr_e;
  // Sequence identifiers, also the memory block index
  typedef enum logic [2:0] {
    SQ_OFF_TO_ACTIVE_SEQ = 3'h0, // off_to_active_seq
    SQ_ACTIVE_TO_OFF_SEQ = 3'h1, // active_to_off_seq
    SQ_ACTIVE_TO_SLEEP_SEQ = 3'h2, // active_to_sleep_seq
    SQ_SLEEP_TO_ACTIVE_SEQ = 3'h3, // sleep_to_active_seq
    SQ_SLEEP_TO_OFF_SEQ = 3'h4 // sleep_to_off_seq
  } pmpsc_seq_e;
  // Sequencer engine states
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0, // No sequence
    ENG_CHECK = 3'h1, // Integrity read-back
    ENG_VERIFY = 3'h2, // Compare sum
    ENG_WAIT = 3'h3, // Wait for slow tick
    ENG_FETCH = 3'h4 // Apply one step
  } pmpsc_eng_e;
  // Integrity check policy codes
  typedef enum logic [1:0] {
    POL_SKIP = 2'h0, // No check
    POL_CONT = 2'h1, // Check, run all
    POL_IO = 2'h2, // On error stop after io rail
    POL_HALT = 2'h3 // On error stop at once
  } pmpsc_pol_e;
endpackage : pmpsc_pkg
`default_nettype wire

// File: pmpsc_ctrl.sv
// Functional notes
// - Four request kinds run one of five sequences
// - Unsequenced resources keep their preloaded defaults
// - Resources are register bits, host or sequencer
// - Transition is ordered register writes
// - Arbitrate concurrent requests into one transition
// - Sequence choice uses request plus supply, temperature
// - Fetch chosen sequence from memory, execute steps
// - Below reset threshold means no-supply state
// - Between reset and low threshold: low-supply
// - Above low threshold, no start: stay off
// - Off state: all off except clock rail
// - Active only after start with high supply
// - Sleep: each resource takes its programmed mode
// - Resource kept on keeps linked subsystems on
// - Sequences do nothing in no-supply or low-supply
// - Hardware enters off; sequencer takes over there
// - Only five transitions are allowed
// - Sequence memory is read only
// - Integrity check at start of power-up
// - Four-option policy on integrity error
// - Integrity error always raises the interrupt
// - Steps paced by the 32 kHz tick
// - Off wins; on honoured once off clears
// - On powers up unless supply or heat gate
// - Sleep only with no unmasked interrupt pending
// - Wake only in sleep: to active or off
`timescale 1ns/10ps
`default_nettype none
`include "pmpsc_cfg.svh"
module pmpsc_ctrl (
  input wire logic core_clk, // System clock, 25 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire logic por_ok, // Rail above power-on reset level
  input wire logic sys_lo_ok, // Rail above system_low_threshold
  input wire logic sys_hi_ok, // Sense above system_high_threshold
  input wire logic hot_die, // Die temperature too high
  input wire logic on_req, // Start-up request level
  input wire logic off_req, // Shutdown request level
  input wire logic wake_req, // Wake request level
  input wire logic sleep_req, // Sleep request level
  input wire logic irq_pending, // Unmasked interrupt pending
  input wire logic [`OTP_DW-1:0] otp_data, // Sequence memory word at otp_addr
  input wire logic [`OTP_DW-1:0] otp_ref_sum, // Preprogrammed check sum
  input wire logic check_en, // Integrity check enabled
  input wire logic [1:0] check_policy, // Integrity error policy
  input wire logic host_wr_en, // Host resource write strobe
  input wire logic [`RES_AW-1:0] host_wr_addr, // Host resource index
  input wire logic [`RES_DW-1:0] host_wr_data, // Host resource data
  input wire logic int_clear, // Clear integrity interrupt
  output logic [2:0] pwr_state, // Current power state
  output logic seq_busy, // A sequence is running
  output logic [`RES_NUM-1:0] res_en, // Resource enables
  output logic [`RES_NUM-1:0] res_lp, // Resource low-power flags
  output logic [`SUB_NUM-1:0] subsys_on, // Linked subsystems kept on
  output logic always_on_clock_rail, // Always-on rail enable
  output logic reg_wr_en, // Sequencer register write pulse
  output logic [`RES_AW-1:0] reg_wr_addr, // Sequencer write index
  output logic [`RES_DW-1:0] reg_wr_data, // Sequencer write data
  output logic [`OTP_AW-1:0] otp_addr, // Sequence memory address
  output logic integrity_error_interrupt // Sticky integrity error flag
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [`SYNC_W-1:0] sync1; // First stage, read only by sync2
  logic [`SYNC_W-1:0] sync2; // Stable copy
  logic s_por, s_lo, s_hi, s_hot, s_on, s_off, s_wake, s_sleep, s_irq;

  // Comparators and request pins are asynchronous to core_clk
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {por_ok, sys_lo_ok, sys_hi_ok, hot_die, on_req, off_req, wake_req, sleep_req, irq_pending};
      sync2 <= sync1;
    end
  end
  assign {s_por, s_lo, s_hi, s_hot, s_on, s_off, s_wake, s_sleep, s_irq} = sync2;

  // ----------------------------------------
  // Slow tick divider
  // ----------------------------------------
  logic [`TICK_W-1:0] tick_cnt; // Core cycles within one RC period
  logic tick; // One-cycle slow tick

  // Stands in for the RC oscillator; one period per sequence step
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 10'h000;
      tick <= 1'b0;
    end else if (tick_cnt == 10'(`RC_TICK_CYC - 1)) begin
      tick_cnt <= 10'h000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 10'h001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event arbitration
  // ----------------------------------------
  pmpsc_pkg::pmpsc_pwr_e pwr; // Power state register
  pmpsc_pkg::pmpsc_eng_e eng; // Sequencer engine state
  logic arb_valid; // A legal transition is requested
  pmpsc_pkg::pmpsc_seq_e arb_id; // Chosen sequence

  // Priority off, on, sleep, wake; anything else is dropped
  always_comb begin
    arb_valid = 1'b0;
    arb_id = pmpsc_pkg::SQ_OFF_TO_ACTIVE_SEQ;
    case (pwr)
      pmpsc_pkg::PWR_OFF: begin
        // On waits for off to clear and for supply and heat gates
        if (s_on && !s_off && s_hi && !s_hot) begin
          arb_valid = 1'b1;
        end
      end
      pmpsc_pkg::PWR_ACT: begin
        if (s_off) begin
          arb_valid = 1'b1;
          arb_id = pmpsc_pkg::SQ_ACTIVE_TO_OFF_SEQ;
        end else if (s_sleep && !s_irq) begin
          arb_valid = 1'b1;
          arb_id = pmpsc_pkg::SQ_ACTIVE_TO_SLEEP_SEQ;
        end
      end
      pmpsc_pkg::PWR_SLP: begin
        if (s_off) begin
          arb_valid = 1'b1;
          arb_id = pmpsc_pkg::SQ_SLEEP_TO_OFF_SEQ;
        end else if (s_wake) begin
          // Wake with sagging supply goes down rather than up
          arb_valid = 1'b1;
          arb_id = s_hi ? pmpsc_pkg::SQ_SLEEP_TO_ACTIVE_SEQ : pmpsc_pkg::SQ_SLEEP_TO_OFF_SEQ;
        end
      end
      default: begin
        // No-supply and low-supply ignore every request
        arb_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer engine
  // ----------------------------------------
  pmpsc_pkg::pmpsc_seq_e seq_id; // Running sequence
  logic [1:0] step_idx; // Step within the sequence
  logic [`OTP_DW-1:0] chk_sum; // Running check sum
  logic stop_at_io; // Truncate after the io rail step
  logic halt_seq; // Power-up abandoned
  logic chk_err; // Integrity error seen this cycle
  logic seq_end; // Last step applied this cycle
  logic step_last; // Current word ends the sequence
  logic supply_ok; // Both supply levels good

  assign supply_ok = s_por && s_lo;
  assign step_last = otp_data[`STEP_LAST] || (step_idx == `SEQ_LAST_STEP)
                     || (stop_at_io && otp_data[`STEP_IO]);
  assign seq_end = (eng == pmpsc_pkg::ENG_FETCH) && step_last && supply_ok;
  assign chk_err = (eng == pmpsc_pkg::ENG_VERIFY) && (chk_sum != otp_ref_sum);

  // Memory is only ever read: no write path exists
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      eng <= pmpsc_pkg::ENG_IDLE;
      seq_id <= pmpsc_pkg::SQ_OFF_TO_ACTIVE_SEQ;
      step_idx <= 2'h0;
      chk_sum <= 13'h0000;
      stop_at_io <= 1'b0;
      halt_seq <= 1'b0;
      otp_addr <= 5'h00;
    end else if (!supply_ok) begin
      // Supply loss abandons any sequence
      eng <= pmpsc_pkg::ENG_IDLE;
      halt_seq <= 1'b0;
    end else begin
      case (eng)
        pmpsc_pkg::ENG_IDLE: begin
          halt_seq <= 1'b0;
          stop_at_io <= 1'b0;
          step_idx <= 2'h0;
          // New request only taken when idle
          if (arb_valid) begin
            seq_id <= arb_id;
            if (arb_id == pmpsc_pkg::SQ_OFF_TO_ACTIVE_SEQ && check_en && check_policy != pmpsc_pkg::POL_SKIP) begin
              eng <= pmpsc_pkg::ENG_CHECK;
              chk_sum <= 13'h0000;
              otp_addr <= 5'h00;
            end else begin
              eng <= pmpsc_pkg::ENG_WAIT;
            end
          end
        end
        pmpsc_pkg::ENG_CHECK: begin
          // Fold every stored word, one per core cycle
          chk_sum <= chk_sum ^ otp_data;
          if (otp_addr == `OTP_LAST_ADDR) begin
            eng <= pmpsc_pkg::ENG_VERIFY;
          end else begin
            otp_addr <= otp_addr + 5'h01;
          end
        end
        pmpsc_pkg::ENG_VERIFY: begin
          eng <= pmpsc_pkg::ENG_WAIT;
          if (chk_err && check_policy == pmpsc_pkg::POL_HALT) begin
            halt_seq <= 1'b1;
            eng <= pmpsc_pkg::ENG_IDLE;
          end else if (chk_err && check_policy == pmpsc_pkg::POL_IO) begin
            stop_at_io <= 1'b1;
          end
        end
        pmpsc_pkg::ENG_WAIT: begin
          if (tick) begin
            otp_addr <= {seq_id, step_idx};
            eng <= pmpsc_pkg::ENG_FETCH;
          end
        end
        pmpsc_pkg::ENG_FETCH: begin
          // Steps run strictly in order
          if (step_last) begin
            eng <= pmpsc_pkg::ENG_IDLE;
          end else begin
            step_idx <= step_idx + 2'h1;
            eng <= pmpsc_pkg::ENG_WAIT;
          end
        end
        default: begin
          eng <= pmpsc_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // Write strobe toward the resource bank
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_wr_en <= 1'b0;
      reg_wr_addr <= 3'h0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_en <= (eng == pmpsc_pkg::ENG_FETCH) && supply_ok;
      reg_wr_addr <= otp_data[`STEP_ADDR_HI:`STEP_ADDR_LO];
      reg_wr_data <= otp_data[`STEP_DATA_HI:0];
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  logic halt_end; // Halted power-up returns to off

  assign halt_end = (eng == pmpsc_pkg::ENG_VERIFY) && chk_err && check_policy == pmpsc_pkg::POL_HALT;

  // Supply levels override; otherwise only sequence ends move state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwr <= pmpsc_pkg::PWR_NOSUP;
    end else if (!s_por) begin
      pwr <= pmpsc_pkg::PWR_NOSUP;
    end else if (!s_lo) begin
      pwr <= pmpsc_pkg::PWR_LOWSUP;
    end else begin
      case (pwr)
        pmpsc_pkg::PWR_NOSUP, pmpsc_pkg::PWR_LOWSUP: begin
          pwr <= pmpsc_pkg::PWR_OFF;
        end
        default: begin
          // Off holds until a power-up sequence completes
          if (halt_end) begin
            pwr <= pmpsc_pkg::PWR_OFF;
          end else if (seq_end) begin
            case (seq_id)
              pmpsc_pkg::SQ_OFF_TO_ACTIVE_SEQ: pwr <= pmpsc_pkg::PWR_ACT;
              pmpsc_pkg::SQ_SLEEP_TO_ACTIVE_SEQ: pwr <= pmpsc_pkg::PWR_ACT;
              pmpsc_pkg::SQ_ACTIVE_TO_SLEEP_SEQ: pwr <= pmpsc_pkg::PWR_SLP;
              default: pwr <= pmpsc_pkg::PWR_OFF;
            endcase
          end
        end
      endcase
    end
  end

  // Status outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwr_state <= 3'h0;
      seq_busy <= 1'b0;
      always_on_clock_rail <= 1'b0;
    end else begin
      pwr_state <= pwr;
      seq_busy <= (eng != pmpsc_pkg::ENG_IDLE);
      always_on_clock_rail <= s_por;
    end
  end

  // Sticky interrupt; a new error beats a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      integrity_error_interrupt <= 1'b0;
    end else if (chk_err) begin
      integrity_error_interrupt <= 1'b1;
    end else if (int_clear) begin
      integrity_error_interrupt <= 1'b0;
    end
  end

  // ----------------------------------------
  // Resource bank and outputs
  // ----------------------------------------
  logic [`RES_DW-1:0] res_reg [`RES_NUM]; // Resource control words
  logic [63:0] res_def; // Preloaded defaults
  logic [31:0] sub_link; // Subsystem link masks

  assign res_def = `RES_DEFAULTS;
  assign sub_link = `SUB_LINKS;

  for (genvar gi = 0; gi < `RES_NUM; gi++) begin : g_res
    // Host writes are held off while a sequence owns the bank
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        res_reg[gi] <= 8'h00;
      end else if (pwr == pmpsc_pkg::PWR_NOSUP || pwr == pmpsc_pkg::PWR_LOWSUP) begin
        res_reg[gi] <= res_def[gi*8 +: 8];
      end else if (reg_wr_en && reg_wr_addr == 3'(gi)) begin
        res_reg[gi] <= reg_wr_data;
      end else if (host_wr_en && eng == pmpsc_pkg::ENG_IDLE && host_wr_addr == 3'(gi)) begin
        res_reg[gi] <= host_wr_data;
      end
    end

    // Enable and low-power flag from state and programmed mode
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        res_en[gi] <= 1'b0;
        res_lp[gi] <= 1'b0;
      end else if (pwr == pmpsc_pkg::PWR_ACT) begin
        res_en[gi] <= res_reg[gi][`RES_EN_BIT];
        res_lp[gi] <= 1'b0;
      end else if (pwr == pmpsc_pkg::PWR_SLP) begin
        // Mode 0 on, 1 sleep, 2 and 3 off
        // A resource already off in active never wakes up in sleep
        res_en[gi] <= res_reg[gi][`RES_EN_BIT] && !res_reg[gi][`RES_SLP_HI];
        res_lp[gi] <= res_reg[gi][`RES_EN_BIT] && (res_reg[gi][`RES_SLP_HI:`RES_SLP_LO] == 2'h1);
      end else begin
        res_en[gi] <= 1'b0;
        res_lp[gi] <= 1'b0;
      end
    end
  end

  // One cycle behind res_en; cheap and glitch free
  for (genvar gj = 0; gj < `SUB_NUM; gj++) begin : g_sub
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        subsys_on[gj] <= 1'b0;
      end else begin
        subsys_on[gj] <= |(res_en & sub_link[gj*8 +: 8]);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_off_seen;
    eng == pmpsc_pkg::ENG_IDLE && pwr == pmpsc_pkg::PWR_ACT && s_off && supply_ok;
  endsequence
  sequence s_active_to_off_seq_run;
    eng == pmpsc_pkg::ENG_WAIT && seq_id == pmpsc_pkg::SQ_ACTIVE_TO_OFF_SEQ;
  endsequence

  a_nosup_state: assert property (!s_por |=> pwr == pmpsc_pkg::PWR_NOSUP)
    else $error("no-supply not entered");
  a_lowsup_state: assert property (s_por && !s_lo |=> pwr == pmpsc_pkg::PWR_LOWSUP)
    else $error("low-supply not entered");
  a_hw_off_entry: assert property ((pwr == pmpsc_pkg::PWR_LOWSUP) && supply_ok |=> pwr == pmpsc_pkg::PWR_OFF)
    else $error("hardware off entry missed");
  a_off_rails_off: assert property (pwr == pmpsc_pkg::PWR_OFF |=> res_en == 8'h00)
    else $error("resource on in off state");
  a_active_from: assert property ($changed(pwr) && pwr == pmpsc_pkg::PWR_ACT
    |-> $past(pwr) == pmpsc_pkg::PWR_OFF || $past(pwr) == pmpsc_pkg::PWR_SLP)
    else $error("illegal entry to active");
  a_off_priority: assert property (s_off_seen |=> s_active_to_off_seq_run)
    else $error("off request not taken first");
  a_sleep_gated: assert property (eng == pmpsc_pkg::ENG_IDLE && pwr == pmpsc_pkg::PWR_ACT
    && s_sleep && s_irq && !s_off |=> eng == pmpsc_pkg::ENG_IDLE)
    else $error("sleep taken with interrupt pending");
  a_on_gated: assert property (eng == pmpsc_pkg::ENG_IDLE && pwr == pmpsc_pkg::PWR_OFF
    && (!s_hi || s_hot) |=> eng == pmpsc_pkg::ENG_IDLE)
    else $error("power-up despite gate");
  a_step_on_tick: assert property (reg_wr_en |-> $past(tick, 2))
    else $error("step not paced by tick");
  a_step_spacing: assert property (reg_wr_en |=> !reg_wr_en [*8])
    else $error("steps too close");
  a_err_irq: assert property (chk_err |=> integrity_error_interrupt)
    else $error("integrity interrupt missing");
  a_no_seq_lowsup: assert property (!supply_ok |=> eng == pmpsc_pkg::ENG_IDLE ##1 !reg_wr_en)
    else $error("sequence ran without supply");
  a_halt_stays_off: assert property (halt_seq |-> pwr == pmpsc_pkg::PWR_OFF && !reg_wr_en)
    else $error("halted power-up left off state");

endmodule : pmpsc_ctrl
`default_nettype wire

// File: pmpsc_otp_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmpsc_cfg.svh"
module pmpsc_otp_model (
  input wire logic [`OTP_AW-1:0] otp_addr, // Word address from sequencer
  output logic [`OTP_DW-1:0] otp_data // Word at that address
);
  // --------------------------------
  // Sequence image, four words a block
  // --------------------------------
  // Constant on purpose: the fuses cannot be rewritten at run time
  localparam logic [`OTP_DW-1:0] IMG [0:19] = '{
    13'h0001, 13'h0901, 13'h1501, 13'h0000, // Power-up, io mark on second step
    13'h0000, 13'h0100, 13'h1500, 13'h0000, // Power-down
    13'h0003, 13'h0104, 13'h1501, 13'h0000, // Into sleep: on+lp, off, on
    13'h0001, 13'h1101, 13'h0000, 13'h0000, // Out of sleep
    13'h0000, 13'h0100, 13'h1500, 13'h0000 // Sleep to off
  };
  // --------------------------------
  // Same-cycle read port
  // --------------------------------
  // Beyond the image the bus shows junk, not a stale word
  assign otp_data = (otp_addr <= `OTP_LAST_ADDR) ? IMG[otp_addr] : ~IMG[otp_addr[1:0]];
endmodule : pmpsc_otp_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmpsc_cfg.svh"
module tb;
  // --------------------------------
  // Stimulus and observed signals
  // --------------------------------
  logic core_clk = 1'b0, reset = 1'b1, por_ok = 1'b0, sys_lo_ok = 1'b0, sys_hi_ok = 1'b1, hot_die = 1'b0;
  logic on_req = 1'b0, off_req = 1'b0, wake_req = 1'b0, sleep_req = 1'b0, irq_pending = 1'b0;
  logic check_en = 1'b0, host_wr_en = 1'b0, int_clear = 1'b0; // Controls set or pulsed by tasks
  logic [1:0] check_policy = 2'h0; // Error policy code
  logic [`OTP_DW-1:0] otp_data, otp_ref_sum = 13'h0000; // Memory word and reference
  logic [`RES_AW-1:0] host_wr_addr = 3'h0, reg_wr_addr;
  logic [`RES_DW-1:0] host_wr_data = 8'h00, reg_wr_data;
  logic [`RES_NUM-1:0] res_en, res_lp;
  logic [`SUB_NUM-1:0] subsys_on;
  logic [`OTP_AW-1:0] otp_addr;
  logic [2:0] pwr_state;
  logic seq_busy, always_on_clock_rail, reg_wr_en, integrity_error_interrupt;
  logic [10:0] last_wr = 11'h000; // Index and data of the latest step
  int num_errors = 0, n_checks = 0, n_wr = 0, n_busy = 0; // Tallies
  localparam logic [7:0] S_NOS = 8'(pmpsc_pkg::PWR_NOSUP), S_LOW = 8'(pmpsc_pkg::PWR_LOWSUP),
    S_OFF = 8'(pmpsc_pkg::PWR_OFF), S_ACT = 8'(pmpsc_pkg::PWR_ACT), S_SLP = 8'(pmpsc_pkg::PWR_SLP);
  pmpsc_ctrl DUT (.core_clk(core_clk), .reset(reset), .por_ok(por_ok), .sys_lo_ok(sys_lo_ok),
    .sys_hi_ok(sys_hi_ok), .hot_die(hot_die), .on_req(on_req), .off_req(off_req), .wake_req(wake_req),
    .sleep_req(sleep_req), .irq_pending(irq_pending), .otp_data(otp_data), .otp_ref_sum(otp_ref_sum),
    .check_en(check_en), .check_policy(check_policy), .host_wr_en(host_wr_en), .host_wr_addr(host_wr_addr),
    .host_wr_data(host_wr_data), .int_clear(int_clear), .pwr_state(pwr_state), .seq_busy(seq_busy),
    .res_en(res_en), .res_lp(res_lp), .subsys_on(subsys_on), .always_on_clock_rail(always_on_clock_rail),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .otp_addr(otp_addr),
    .integrity_error_interrupt(integrity_error_interrupt));
  pmpsc_otp_model OTP (.otp_addr(otp_addr), .otp_data(otp_data));
  // --------------------------------
  // Clock, counters, helpers
  // --------------------------------
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Step writes and busy cycles, compared as deltas
  always @(posedge core_clk) begin
    if (reg_wr_en === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= {reg_wr_addr, reg_wr_data};
    end
    if (seq_busy === 1'b1)
      n_busy <= n_busy + 1;
  end
  function automatic logic [`OTP_DW-1:0] xsum();
    logic [`OTP_DW-1:0] s;
    s = 13'h0000;
    for (int i = 0; i < 20; i++)
      s = s ^ OTP.IMG[i];
    return s;
  endfunction : xsum
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (seq_busy !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(seq_busy, v, "busy level");
  endtask : wait_busy
  // Requests are levels, so all are dropped once the engine has taken one
  task automatic run_seq;
    wait_busy(1'b1, 40);
    @(posedge core_clk);
    {on_req, off_req, wake_req, sleep_req} <= 4'h0;
    wait_busy(1'b0, 4000);
    repeat (4) @(negedge core_clk);
  endtask : run_seq
  task automatic quiet(input logic [7:0] st);
    repeat (40) @(negedge core_clk);
    chk(seq_busy, 1'b0, "no sequence");
    chk(pwr_state, st, "state held");
    @(posedge core_clk);
  endtask : quiet
  task automatic set_sup(input logic por, input logic lo, input logic [7:0] st);
    @(posedge core_clk);
    por_ok <= por;
    sys_lo_ok <= lo;
    repeat (8) @(negedge core_clk);
    chk(pwr_state, st, "supply state");
  endtask : set_sup
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_supply_up;
    set_sup(1'b0, 1'b0, S_NOS);
    set_sup(1'b1, 1'b0, S_LOW);
    set_sup(1'b1, 1'b1, S_OFF);
    chk(res_en, 8'h00, "off resources");
    chk(always_on_clock_rail, 1'b1, "clock rail");
  endtask : t_supply_up
  task automatic t_refused;
    @(posedge core_clk);
    {sleep_req, wake_req, hot_die, on_req} <= 4'hF;
    quiet(S_OFF);
    hot_die <= 1'b0;
    sys_hi_ok <= 1'b0;
    quiet(S_OFF);
    {sleep_req, wake_req, on_req, sys_hi_ok} <= 4'h1;
  endtask : t_refused
  task automatic t_power_up;
    int w, b;
    w = n_wr;
    b = n_busy;
    @(posedge core_clk);
    check_en <= 1'b1;
    check_policy <= 2'h3;
    otp_ref_sum <= xsum();
    on_req <= 1'b1;
    run_seq;
    chk(pwr_state, S_ACT, "power-up state");
    chk(res_en, 8'h23, "active resources");
    chk(subsys_on, 4'h3, "linked blocks");
    chk(8'(n_wr - w), 8'h03, "step writes");
    chk(last_wr[7:0], 8'h01, "last step data");
    chk(8'(last_wr[10:8]), 8'h05, "last step index");
    chk(integrity_error_interrupt, 1'b0, "clean image");
    chk(n_busy - b >= 2 * `RC_TICK_CYC && n_busy - b <= 3 * `RC_TICK_CYC + 60, 1'b1, "paced");
  endtask : t_power_up
  task automatic t_host;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      {host_wr_en, host_wr_addr, host_wr_data} <= {1'b1, 3'h3, 8'(1 - i)};
      @(posedge core_clk);
      host_wr_en <= 1'b0;
      repeat (4) @(negedge core_clk);
      chk(res_en, (i == 0) ? 8'h2B : 8'h23, "host bit");
    end
  endtask : t_host
  task automatic t_sleep_wake;
    @(posedge core_clk);
    {irq_pending, sleep_req} <= 2'h3;
    quiet(S_ACT);
    irq_pending <= 1'b0;
    run_seq;
    chk(pwr_state, S_SLP, "sleep entry");
    chk(res_en, 8'h21, "sleep modes");
    chk(res_lp, 8'h01, "sleep low-power");
    chk(subsys_on, 4'h3, "kept links");
    @(posedge core_clk);
    wake_req <= 1'b1;
    run_seq;
    chk(pwr_state, S_ACT, "wake active");
    chk(res_en, 8'h23, "woken resources");
    @(posedge core_clk);
    wake_req <= 1'b1;
    quiet(S_ACT);
    {wake_req, sleep_req} <= 2'h1;
    run_seq;
    @(posedge core_clk);
    {sys_hi_ok, wake_req} <= 2'h1;
    run_seq;
    chk(pwr_state, S_OFF, "wake off");
    chk(res_en, 8'h00, "off again");
    @(posedge core_clk);
    {sys_hi_ok, on_req} <= 2'h3;
    run_seq;
  endtask : t_sleep_wake
  task automatic t_off_wins;
    @(posedge core_clk);
    {on_req, sleep_req, off_req} <= 3'h7;
    wait_busy(1'b1, 40);
    @(posedge core_clk);
    {sleep_req, off_req} <= 2'h0;
    wait_busy(1'b0, 4000);
    chk(pwr_state, S_OFF, "off first");
    run_seq;
    chk(pwr_state, S_ACT, "on after off");
  endtask : t_off_wins
  task automatic t_supply_loss;
    @(posedge core_clk);
    {sys_lo_ok, on_req} <= 2'h1;
    quiet(S_LOW);
    chk(res_en, 8'h00, "defaults back");
    on_req <= 1'b0;
    set_sup(1'b0, 1'b0, S_NOS);
    set_sup(1'b1, 1'b1, S_OFF);
  endtask : t_supply_loss
  task automatic t_check;
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      {check_policy, on_req} <= {2'(p), 1'b1};
      otp_ref_sum <= xsum() ^ 13'h0040;
      run_seq;
      chk(integrity_error_interrupt, p != 0, "error flag");
      chk(pwr_state, (p == 3) ? S_OFF : S_ACT, "policy state");
      chk(res_en, (p == 2) ? 8'h03 : (p == 3) ? 8'h00 : 8'h23, "policy steps");
      @(posedge core_clk);
      {int_clear, off_req} <= {1'b1, p != 3};
      @(posedge core_clk);
      int_clear <= 1'b0;
      if (p != 3)
        run_seq;
      else
        @(negedge core_clk);
      chk(integrity_error_interrupt, 1'b0, "flag cleared");
    end
  endtask : t_check
  // --------------------------------
  // Main sequence and watchdog
  // --------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_supply_up;
    t_refused;
    t_power_up;
    t_host;
    t_sleep_wake;
    t_off_wins;
    t_supply_loss;
    t_check;
    report_and_stop;
  end
  // About fifteen sequences of under 2400 cycles each fit well inside this
  initial begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
